// ---- nand_host_pkg.sv ----
// Constants for the NAND strobe-level host controller.
// Assumes a 200 MHz controller clock and a host-driven, clockless pin link.
package nand_host_pkg;
   // Clock period in ps
   localparam int CLK_PS = 5000;
   // Strobe low and high times in ns
   localparam int T_STROBE_LOW_NS = 25;
   localparam int T_STROBE_HIGH_NS = 15;
   // Latch set-up before strobe falls, ns
   localparam int T_SETUP_NS = 10;
   localparam int LOW_CYC = (T_STROBE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int HIGH_CYC = (T_STROBE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CNT_W = 4;
   // Request kinds
   localparam int KIND_W = 2;
   localparam logic [1:0] KIND_CMD = 2'h0;
   localparam logic [1:0] KIND_ADDR = 2'h1;
   localparam logic [1:0] KIND_DWRITE = 2'h2;
   localparam logic [1:0] KIND_DREAD = 2'h3;
   // Address cycle that carries the die select bit, and its I/O position
   localparam logic [2:0] DIE_ADDR_CYCLE = 3'h4;
   localparam int DIE_BIT_POS = 1;
   localparam int IO_W = 16;
   localparam int FIFO_DEPTH = 16;
   // Die select from one address cycle; same I/O line on both bus widths
   function automatic logic die_of(input logic [IO_W-1:0] d);
      return d[DIE_BIT_POS];
   endfunction : die_of
endpackage : nand_host_pkg

// ---- nand_host_ctrl.sv ----
// Host-side NAND pin sequencer with a read-data FIFO.
// Assumes one NAND device with an open-drain ready/busy line pulled up
// outside, and a user that waits for o_req_ready before each request.
`timescale 1ns/1ps
`default_nettype none

module nand_host_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic push;
   logic pop;

   assign o_in_ready = (wptr - rptr) != (AW + 1)'(DEPTH);
   assign o_out_valid = wptr != rptr;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem[rptr[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end
endmodule : nand_host_fifo

// Overview of operation
// [RULE_01] Latch levels select command, address or data input on write strobe.
// [RULE_02] Read strobe toggles with latches low fetch next read or status byte.
// [RULE_03] Device checks write protect only when program or erase starts.
// [RULE_04] Host keeps write protect steady through sequence and busy operation.
// [RULE_05] Device enters standby with chip enable high once operations end.
// [RULE_06] Chip enable may rise between cycles and during busy periods.
// [RULE_07] In a die stack only the last activated die takes commands.
// [RULE_08] Host selects die by an address-bearing command before addressless ones.
// [RULE_09] Reset or suspend acts only on the last activated die.
// [RULE_10] Reset both dies: reset, address other die, reset again.
// [RULE_11] No program, erase or read commands while either die is busy.
// [RULE_12] Address bit above array top selects die; other die in standby.
// [RULE_13] Program works per page, erase per block.
// [RULE_14] Page is 2112 bytes: 2048 main plus 64 spare.
// [RULE_15] Page has four 512-byte main and four 16-byte spare segments.
// [RULE_16] Block is 64 pages, 128 KB; 4096 to 512 blocks by density.
// [RULE_17] Byte-bus address fields: area, segments, columns, page, block.
// [RULE_18] Word-bus address fields: area, segments, columns, page, block.
// [RULE_19] Bytes are captured on write strobe rising edge with chip enable low.
// [RULE_20] Read strobe falling edge drives next word, column counter plus one.
// [RULE_21] Ready/busy pulled low during program, erase and read.
// [RULE_22] Word bus: upper eight I/O lines low in command and address cycles.
module nand_host_ctrl #(
   parameter int FIFO_WORDS = nand_host_pkg::FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_bus16,
   input wire logic i_wp_n,
   input wire logic i_req_valid,
   input wire logic [nand_host_pkg::KIND_W-1:0] i_req_kind,
   input wire logic [nand_host_pkg::IO_W-1:0] i_req_data,
   input wire logic i_req_safe,
   output logic o_req_ready,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [nand_host_pkg::IO_W-1:0] o_rd_data,
   output logic o_busy,
   output logic o_active_die,
   output logic o_cle,
   output logic o_ale,
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_read_strobe_n,
   output logic o_wp_n,
   input wire logic [nand_host_pkg::IO_W-1:0] i_io,
   output logic [nand_host_pkg::IO_W-1:0] o_io,
   output logic o_io_oe_n,
   input wire logic i_ready_busy_n
);
   import nand_host_pkg::*;

   typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH} phase_e;

   phase_e state;
   logic [CNT_W-1:0] cnt;
   logic [KIND_W-1:0] kind;
   logic [2:0] addr_idx;
   logic rb_s1;
   logic rb_s2;
   logic rb_s3;
   logic ready;
   logic ready_d;
   logic seq_open;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [IO_W-1:0] rd_word;
   logic take;
   logic last_cnt;

   // Ready/busy sync, three stages, accept when last two agree
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
         rb_s3 <= 1'b1;
         ready <= 1'b1;
         ready_d <= 1'b1;
      end else begin
         rb_s1 <= i_ready_busy_n;
         rb_s2 <= rb_s1;
         rb_s3 <= rb_s2;
         ready_d <= ready;
         // [RULE_21] busy seen low
         if (rb_s2 == rb_s3) begin
            ready <= rb_s3;
         end
      end
   end

   assign o_busy = !ready;
   assign last_cnt = cnt == '0;

   // [RULE_11] hold non-safe requests while busy; reads wait for FIFO room
   always_comb begin
      o_req_ready = state == ST_IDLE && (ready || i_req_safe);
      if (i_req_kind == KIND_DREAD && !fifo_in_ready) begin
         o_req_ready = 1'b0;
      end
   end
   assign take = i_req_valid && o_req_ready;

   // Strobe phase sequencer
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         cnt <= '0;
         kind <= KIND_CMD;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take) begin
                  state <= ST_SETUP;
                  kind <= i_req_kind;
                  cnt <= CNT_W'(SETUP_CYC - 1);
               end
            end
            ST_SETUP: begin
               if (last_cnt) begin
                  state <= ST_LOW;
                  cnt <= CNT_W'(LOW_CYC - 1);
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ST_LOW: begin
               if (last_cnt) begin
                  state <= ST_HIGH;
                  cnt <= CNT_W'(HIGH_CYC - 1);
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ST_HIGH: begin
               if (last_cnt) begin
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // [RULE_01] latch levels by request kind
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cle <= 1'b0;
         o_ale <= 1'b0;
      end else if (take) begin
         o_cle <= i_req_kind == KIND_CMD;
         o_ale <= i_req_kind == KIND_ADDR;
      end else if (state == ST_HIGH && last_cnt) begin
         o_cle <= 1'b0;
         o_ale <= 1'b0;
      end
   end

   // [RULE_06] chip enable only around each cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ce_n <= 1'b1;
      end else if (take) begin
         o_ce_n <= 1'b0;
      end else if (state == ST_HIGH && last_cnt) begin
         o_ce_n <= 1'b1;
      end
   end

   // [RULE_19] write strobe rises at end of low phase, CE still low
   // [RULE_02] read strobe pulses with both latches low
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_we_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
      end else if (state == ST_SETUP && last_cnt) begin
         o_we_n <= kind == KIND_DREAD;
         o_read_strobe_n <= kind != KIND_DREAD;
      end else if (state == ST_LOW && last_cnt) begin
         o_we_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
      end
   end

   // [RULE_22] upper lines low for command and address on word bus
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_io <= '0;
         o_io_oe_n <= 1'b1;
      end else if (take) begin
         o_io_oe_n <= i_req_kind == KIND_DREAD;
         o_io <= i_req_data;
         if (i_req_kind != KIND_DWRITE || !i_bus16) begin
            o_io[IO_W-1:8] <= '0;
         end
      end else if (state == ST_HIGH && last_cnt) begin
         o_io_oe_n <= 1'b1;
      end
   end

   // [RULE_20] sample word at end of read strobe low phase
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_word <= '0;
         fifo_in_valid <= 1'b0;
      end else begin
         fifo_in_valid <= state == ST_LOW && last_cnt && kind == KIND_DREAD;
         if (state == ST_LOW && last_cnt && kind == KIND_DREAD) begin
            rd_word <= i_bus16 ? i_io : {8'h00, i_io[7:0]};
         end
      end
   end

   // [RULE_08] track die from the fifth address cycle
   // [RULE_12] die select bit is above the array top
   // [RULE_10] die follows address
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         addr_idx <= '0;
         o_active_die <= 1'b0;
      end else if (take && i_req_kind == KIND_CMD) begin
         addr_idx <= '0;
      end else if (take && i_req_kind == KIND_ADDR) begin
         if (addr_idx == DIE_ADDR_CYCLE) begin
            o_active_die <= die_of(i_req_data);
         end
         if (addr_idx != 3'h7) begin
            addr_idx <= addr_idx + 1'b1;
         end
      end
   end

   // [RULE_04] write protect only changes outside a sequence and busy time
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         seq_open <= 1'b0;
         o_wp_n <= 1'b0;
      end else begin
         if (take && i_req_kind == KIND_CMD) begin
            seq_open <= 1'b1;
         end else if (ready && !ready_d) begin
            seq_open <= 1'b0;
         end else if (take && i_req_kind == KIND_DREAD) begin
            seq_open <= 1'b0;
         end
         if (!seq_open && ready && state == ST_IDLE && !take) begin
            o_wp_n <= i_wp_n;
         end
      end
   end

   nand_host_fifo #(
      .WIDTH(IO_W),
      .DEPTH(FIFO_WORDS)
   ) u_rd_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(rd_word),
      .o_out_valid(o_rd_valid),
      .i_out_ready(i_rd_ready),
      .o_out_data(o_rd_data)
   );
endmodule : nand_host_ctrl

`default_nettype wire

// ---- nand_host_ctrl_checker.sv ----
// Pin sequencing checks for nand_host_ctrl.
// Assumes the top module's ports only; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_checker (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_req_safe,
   input wire logic o_req_ready,
   input wire logic o_busy,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_ce_n,
   input wire logic o_we_n,
   input wire logic o_read_strobe_n,
   input wire logic o_wp_n,
   input wire logic [nand_host_pkg::IO_W-1:0] o_io,
   input wire logic o_io_oe_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   we_qualified_a: assert property (!o_we_n |->
      !o_ce_n && !(o_cle && o_ale) && !o_io_oe_n) else $error("bad write");
   read_qualified_a: assert property (!o_read_strobe_n |->
      o_we_n && o_io_oe_n && !o_cle && !o_ale && !o_ce_n)
      else $error("bad read");
   we_width_a: assert property ($fell(o_we_n) |->
      !o_we_n [*5] ##1 o_we_n) else $error("write strobe width");
   capture_hold_a: assert property ($rose(o_we_n) |->
      !o_ce_n && $stable(o_io) && $stable(o_cle) && $stable(o_ale))
      else $error("capture edge unstable");
   re_width_a: assert property ($fell(o_read_strobe_n) |->
      !o_read_strobe_n [*5] ##1 o_read_strobe_n) else $error("read width");
   wp_steady_a: assert property (o_busy && $past(o_busy) |->
      $stable(o_wp_n)) else $error("wp moved while busy");
   upper_low_a: assert property (!o_io_oe_n && (o_cle || o_ale) |->
      o_io[15:8] == 8'h00) else $error("upper io not low");
   busy_refuse_a: assert property (o_busy && !i_req_safe |->
      !o_req_ready) else $error("request open while busy");
endmodule : nand_host_ctrl_checker
bind nand_host_ctrl nand_host_ctrl_checker u_nand_host_ctrl_checker (
   .i_clk, .i_arst_n, .i_req_safe, .o_req_ready, .o_busy, .o_cle, .o_ale,
   .o_ce_n, .o_we_n, .o_read_strobe_n, .o_wp_n, .o_io, .o_io_oe_n);
`default_nettype wire

// ---- nand_dev_model.sv ----
// Behavioural NAND device for the host controller bench.
// Assumes strobes from the controller; the model drives ready/busy both high and low.
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
   parameter int BUSY_NS = 400
) (
   input wire logic i_bus16,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_re_n,
   input wire logic i_wp_n,
   input wire logic [15:0] i_io,
   output logic [15:0] o_io,
   output logic o_rb_n,
   output logic [7:0] o_cmd,
   output logic [15:0] o_data,
   output logic o_die,
   output logic [7:0] o_n_prog,
   output logic [2:0] o_n_addr
);
   logic [15:0] col;
   event go;
   initial begin
      {o_rb_n, o_io, o_cmd, o_data, o_die, o_n_prog, o_n_addr} = 0;
      o_rb_n = 1'b1;
      col = 16'h0000;
   end
   always @(posedge i_we_n) if (!i_ce_n) begin
      if (i_cle) begin
         o_cmd = i_io[7:0];
         o_n_addr = 3'h0;
         // Busy on program or read start
         if (i_io[7:0] == 8'h30 || (i_io[7:0] == 8'h10 && i_wp_n)) begin
            o_n_prog = o_n_prog + {7'h00, i_io[7:0] == 8'h10};
            -> go;
         end
      end else if (i_ale) begin
         if (o_n_addr == 3'h0) col = {8'h00, i_io[7:0]};
         if (o_n_addr == 3'h1) col[15:8] = i_bus16 ? {5'h00, i_io[2:0]} :
            {4'h0, i_io[3:0]};
         if (o_n_addr == 3'h4) o_die = i_io[1];
         o_n_addr = o_n_addr + 3'h1;
      end else o_data = i_io;
   end
   always @(go) begin
      o_rb_n = 1'b0;
      #(BUSY_NS);
      o_rb_n = 1'b1;
   end
   always @(negedge i_re_n) if (!i_ce_n && !i_cle && !i_ale) begin
      o_io = 16'h5aa5 ^ col;
      col = col + 16'h0001;
   end
   // Released bus shows no stale word
   always @(posedge i_re_n) o_io = ~o_io;
endmodule : nand_dev_model
`default_nettype wire

// ---- tb_nand_host.sv ----
// Self-checking bench for nand_host_ctrl on a 16-bit bus, then on an 8-bit bus.
// Assumes nand_dev_model as the far-side device.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nand_host_pkg::*;
   logic i_clk, i_arst_n, i_wp_n, i_req_valid, i_req_safe, i_rd_ready, i_bus16;
   logic [1:0] i_req_kind;
   logic [15:0] i_req_data, o_io, dev_io, o_rd_data, io_bus, m_data;
   logic o_req_ready, o_rd_valid, o_busy, o_active_die, o_cle, o_ale;
   logic o_ce_n, o_we_n, o_read_strobe_n, o_wp_n, o_io_oe_n, rb_n, m_die;
   logic [7:0] m_cmd, m_prog;
   logic [2:0] m_addr;
   int fails, n_checks;
   assign io_bus = o_io_oe_n ? dev_io : o_io;
   nand_host_ctrl u_nand_host_ctrl (.i_clk, .i_arst_n, .i_bus16,
      .i_wp_n, .i_req_valid, .i_req_kind, .i_req_data, .i_req_safe,
      .o_req_ready, .o_rd_valid, .i_rd_ready, .o_rd_data, .o_busy,
      .o_active_die, .o_cle, .o_ale, .o_ce_n, .o_we_n, .o_read_strobe_n,
      .o_wp_n, .i_io(io_bus), .o_io, .o_io_oe_n, .i_ready_busy_n(rb_n));
   nand_dev_model u_nand_dev_model (.i_bus16, .i_cle(o_cle), .i_ale(o_ale),
      .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_re_n(o_read_strobe_n),
      .i_wp_n(o_wp_n), .i_io(io_bus), .o_io(dev_io), .o_rb_n(rb_n),
      .o_cmd(m_cmd), .o_data(m_data), .o_die(m_die), .o_n_prog(m_prog),
      .o_n_addr(m_addr));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic req(input logic [1:0] k, input logic [15:0] d);
      int n;
      n = 0;
      i_req_valid = 1'b1;
      i_req_kind = k;
      i_req_data = d;
      // Ready looked at on the edge itself, as the design samples it
      @(posedge i_clk);
      while (o_req_ready !== 1'b1 && n < 400) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 400) begin
         fails++;
         $display("wrong value request taken expected 1 seen 0");
      end
      #1;
      i_req_valid = 1'b0;
      tick(1);
   endtask : req
   task automatic addr5(input logic [15:0] last);
      for (int i = 0; i < 4; i++) req(KIND_ADDR, 16'(i));
      req(KIND_ADDR, last);
   endtask : addr5
   task automatic program_page;
      req(KIND_CMD, 16'h0080);
      addr5(16'h0000);
      req(KIND_DWRITE, 16'h1234);
      req(KIND_CMD, 16'h0010);
      tick(20);
   endtask : program_page
   task automatic wait_idle;
      for (int n = 0; n < 400 && o_busy !== 1'b0; n++) tick(1);
   endtask : wait_idle
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #100us;
      fails++;
      end_of_test();
   end
   initial begin
      {i_arst_n, i_req_valid, i_req_safe, i_rd_ready} = 4'h0;
      i_wp_n = 1'b1;
      i_bus16 = 1'b1;
      i_req_kind = KIND_CMD;
      i_req_data = 16'h0000;
      tick(12);
      chk("idle pins", 16'h0078, {7'h00, o_cle, o_ale, o_ce_n, o_we_n,
         o_read_strobe_n, o_io_oe_n, o_rd_valid, o_busy, o_active_die});
      i_arst_n = 1'b1;
      tick(2);
      req(KIND_CMD, 16'h0000);
      addr5(16'h0002);
      req(KIND_CMD, 16'h0030);
      chk("die", 16'h0001, {15'h0, o_active_die});
      chk("dev die", 16'h0001, {15'h0, m_die});
      chk("addr cycles", 16'h0005, {13'h0, m_addr});
      tick(20);
      chk("busy", 16'h0001, {15'h0, o_busy});
      chk("refused", 16'h0000, {15'h0, o_req_ready});
      wait_idle();
      chk("cmd", 16'h0030, {8'h00, m_cmd});
      for (int k = 0; k < 16; k++) req(KIND_DREAD, 16'h0000);
      i_req_valid = 1'b1;
      i_req_kind = KIND_DREAD;
      tick(15);
      chk("fifo full", 16'h0000, {15'h0, o_req_ready});
      i_req_valid = 1'b0;
      i_rd_ready = 1'b1;
      for (int k = 0; k < 16; k++) begin
         chk("read word", 16'h5ba5 ^ 16'(k), o_rd_data);
         tick(1);
      end
      chk("fifo empty", 16'h0000, {15'h0, o_rd_valid});
      i_wp_n = 1'b0;
      tick(3);
      program_page();
      chk("die 0", 16'h0000, {15'h0, o_active_die});
      chk("blocked", 16'h0000, {7'h0, o_busy, m_prog});
      chk("data in", 16'h1234, m_data);
      req(KIND_DREAD, 16'h0000);
      i_wp_n = 1'b1;
      tick(12);
      program_page();
      chk("programs", 16'h0001, {8'h00, m_prog});
      i_wp_n = 1'b0;
      tick(10);
      chk("wp held", 16'h0001, {15'h0, o_wp_n});
      i_req_safe = 1'b1;
      req(KIND_CMD, 16'h00ff);
      tick(8);
      chk("safe cmd", 16'h00ff, {8'h00, m_cmd});
      i_req_safe = 1'b0;
      wait_idle();
      // Byte bus: switch to die 1, reset it, then one write and one read
      i_bus16 = 1'b0;
      i_rd_ready = 1'b0;
      req(KIND_CMD, 16'h0000);
      addr5(16'h0002);
      req(KIND_CMD, 16'h00ff);
      req(KIND_DWRITE, 16'hab12);
      req(KIND_DREAD, 16'h0000);
      tick(12);
      chk("second die", 16'h01ff, {7'h00, m_die, m_cmd});
      chk("host die", 16'h0001, {15'h0, o_active_die});
      chk("x8 data in", 16'h0012, m_data);
      chk("x8 read", 16'h00a5, o_rd_data);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
